//--- src/sdram_addr_map_consts.vh
// constants for the sdram address mapper
// assumes inclusion by bare name from src/
`ifndef SDRAM_ADDR_MAP_CONSTS_VH
`define SDRAM_ADDR_MAP_CONSTS_VH
`define AW              28
`define COL_W_MAX       11
`define ROW_W_MAX       13
`define BANK_W          2
`define LANE_W          2
`define BUS_32          1'h1
`define BUS_16          1'h0
`define COLS_256        2'h0
`define COLS_512        2'h1
`define COLS_1024       2'h2
`define COLS_2048       2'h3
`define ROWS_2K         2'h0
`define ROWS_4K         2'h1
`define ROWS_8K         2'h2
`define COL_W_256       4'h8
`define COL_W_512       4'h9
`define COL_W_1024      4'hA
`define COL_W_2048      4'hB
`define ROW_W_2K        4'hB
`define ROW_W_4K        4'hC
`define ROW_W_8K        4'hD
`define LANE_W32        4'h2
`define LANE_W16        4'h1
`define LANE_LSB        0
`define LANE_MSB_32     1
`define BANK_FIELD_W    5'h2
`define BANK_HI_POS     1
`define BANK_LO_POS     0
`define RST_VALID       1'h0
`define RST_LANE        2'h0
`define RST_HALF_LANE   1'h0
`define RST_COLUMN      11'h000
`define RST_ROW         13'h0000
`define RST_BANK        2'h0
`define RST_BANK_PIN    1'h0
`endif

//--- src/sdram_addr_map.v
// sdram address mapper: splits a linear cpu byte address into
// byte lane, column, row and bank fields.
// assumes configuration inputs are static while requests flow.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_addr_map_consts.vh"

// Functional notes
// R1: linear address mapped to sdram fields automatically
// R2: 32-bit bus: two lane bits, column at bit 2
// R3: 16-bit bus: one lane bit, column at bit 1
// R4: column width 8 to 11 bits from config
// R5: 2K rows: 11-bit row above column
// R6: 4K rows: 12-bit row above column
// R7: 8K rows: 13-bit row above column
// R8: 2-bit bank above row drives bank selects
// R9: software sets bus width in mode setting
// R10: software sets column and row counts first
// R11: bits above bank field ignored, image repeats
module sdram_addr_map
(
    input  wire                    core_clk_i,
    input  wire                    nrst_i,
    input  wire                    req_valid_i,
    input  wire [`AW-1:0]          cpu_addr_i,
    input  wire                    bus_is_32_i,
    input  wire [1:0]              col_cfg_i,
    input  wire [1:0]              row_cfg_i,
    output wire                    map_valid_o,
    output wire [1:0]              byte_lane_o,
    output wire                    halfword_byte_lane_o,
    output wire [`COL_W_MAX-1:0]   column_o,
    output wire [`ROW_W_MAX-1:0]   row_o,
    output wire [`BANK_W-1:0]      bank_field_o,
    output wire                    bank_select_hi_o,
    output wire                    bank_select_lo_o
);

    // lane bits below the column: two on a word bus, one on a half-word bus
    function [3:0] lane_width;
        input bus32;
        begin
            if (bus32 == `BUS_32)
            begin
                lane_width = `LANE_W32;
            end
            else
            begin
                lane_width = `LANE_W16;
            end
        end
    endfunction

    function [3:0] col_width;
        input [1:0] code;
        begin
            case (code)
                `COLS_256:  col_width = `COL_W_256;
                `COLS_512:  col_width = `COL_W_512;
                `COLS_1024: col_width = `COL_W_1024;
                `COLS_2048: col_width = `COL_W_2048;
                default:    col_width = `COL_W_256;
            endcase
        end
    endfunction

    // reserved code falls back to the widest row so no address bit is lost
    function [3:0] row_width;
        input [1:0] code;
        begin
            case (code)
                `ROWS_2K: row_width = `ROW_W_2K;
                `ROWS_4K: row_width = `ROW_W_4K;
                `ROWS_8K: row_width = `ROW_W_8K;
                default:  row_width = `ROW_W_8K;
            endcase
        end
    endfunction

    function [`AW-1:0] low_mask;
        input [4:0] width;
        begin
            low_mask = ~({`AW{1'h1}} << width);
        end
    endfunction

    // one field: shift its lowest bit down, keep width bits
    function [`AW-1:0] take_field;
        input [`AW-1:0] addr;
        input [4:0]     lsb;
        input [4:0]     width;
        begin
            take_field = (addr >> lsb) & low_mask(width);
        end
    endfunction

    reg  [3:0]             lane_w;
    reg  [3:0]             col_w;
    reg  [3:0]             row_w;
    reg  [4:0]             col_lsb;
    reg  [4:0]             row_lsb;
    reg  [4:0]             bank_lsb;
    reg  [`AW-1:0]         col_raw;
    reg  [`AW-1:0]         row_raw;
    reg  [`AW-1:0]         bank_raw;

    reg                    map_valid_d;
    reg                    map_valid_q;
    reg  [1:0]             byte_lane_d;
    reg  [1:0]             byte_lane_q;
    reg                    halfword_byte_lane_d;
    reg                    halfword_byte_lane_q;
    reg  [`COL_W_MAX-1:0]  column_d;
    reg  [`COL_W_MAX-1:0]  column_q;
    reg  [`ROW_W_MAX-1:0]  row_d;
    reg  [`ROW_W_MAX-1:0]  row_q;
    reg  [`BANK_W-1:0]     bank_field_d;
    reg  [`BANK_W-1:0]     bank_field_q;
    reg                    bank_select_hi_d;
    reg                    bank_select_hi_q;
    reg                    bank_select_lo_d;
    reg                    bank_select_lo_q;

    // config is not resynchronised; it must stay still while requests flow
    always @*
    begin
        lane_w   = lane_width(bus_is_32_i);                       // see R2 see R3
        col_w    = col_width(col_cfg_i);                          // see R4
        row_w    = row_width(row_cfg_i);                          // see R5 see R6 see R7
        col_lsb  = {1'h0, lane_w};
        row_lsb  = col_lsb + {1'h0, col_w};
        bank_lsb = row_lsb + {1'h0, row_w};
    end

    // bits above the bank never reach a field, so the image repeats
    always @*
    begin
        col_raw  = take_field(cpu_addr_i, col_lsb, {1'h0, col_w});    // see R4
        row_raw  = take_field(cpu_addr_i, row_lsb, {1'h0, row_w});    // see R5 see R6 see R7
        bank_raw = take_field(cpu_addr_i, bank_lsb, `BANK_FIELD_W);   // see R8 see R11
    end

    // fields hold between requests so the command side may read them late
    always @*
    begin
        map_valid_d          = req_valid_i;                                 // see R1
        byte_lane_d          = byte_lane_q;
        halfword_byte_lane_d = halfword_byte_lane_q;
        column_d             = column_q;
        row_d                = row_q;
        bank_field_d         = bank_field_q;
        bank_select_hi_d     = bank_select_hi_q;
        bank_select_lo_d     = bank_select_lo_q;
        if (req_valid_i)
        begin
            if (bus_is_32_i == `BUS_32)
            begin
                byte_lane_d = cpu_addr_i[`LANE_MSB_32:`LANE_LSB];           // see R2
            end
            else
            begin
                byte_lane_d = {1'h0, cpu_addr_i[`LANE_LSB]};               // see R3
            end
            halfword_byte_lane_d = cpu_addr_i[`LANE_LSB];                   // see R3
            column_d             = col_raw[`COL_W_MAX-1:0];                // see R4
            row_d                = row_raw[`ROW_W_MAX-1:0];                // see R5 see R6 see R7
            bank_field_d         = bank_raw[`BANK_W-1:0];                  // see R8
            bank_select_hi_d     = bank_raw[`BANK_HI_POS];                 // see R8
            bank_select_lo_d     = bank_raw[`BANK_LO_POS];                 // see R8
        end
    end

    // valid pulses once per request, one cycle after it is taken
    always @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            map_valid_q <= `RST_VALID;
        end
        else
        begin
            map_valid_q <= map_valid_d;
        end
    end

    // first request may follow the reset release at once
    always @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            byte_lane_q          <= `RST_LANE;
            halfword_byte_lane_q <= `RST_HALF_LANE;
            column_q             <= `RST_COLUMN;
            row_q                <= `RST_ROW;
            bank_field_q         <= `RST_BANK;
            bank_select_hi_q     <= `RST_BANK_PIN;
            bank_select_lo_q     <= `RST_BANK_PIN;
        end
        else
        begin
            byte_lane_q          <= byte_lane_d;
            halfword_byte_lane_q <= halfword_byte_lane_d;
            column_q             <= column_d;
            row_q                <= row_d;
            bank_field_q         <= bank_field_d;
            bank_select_hi_q     <= bank_select_hi_d;
            bank_select_lo_q     <= bank_select_lo_d;
        end
    end

    // outputs straight from the flops, no logic after them
    assign map_valid_o          = map_valid_q;
    assign byte_lane_o          = byte_lane_q;
    assign halfword_byte_lane_o = halfword_byte_lane_q;
    assign column_o             = column_q;
    assign row_o                = row_q;
    assign bank_field_o         = bank_field_q;
    assign bank_select_hi_o     = bank_select_hi_q;
    assign bank_select_lo_o     = bank_select_lo_q;

endmodule // sdram_addr_map
`default_nettype wire

//--- sim/sdram_addr_map_checker.sv
// checker: field split of the address mapper
// sees only the sdram_addr_map ports; bound below
`timescale 1ns/1ps
`default_nettype none
module sdram_addr_map_checker(
    input wire logic        core_clk_i, nrst_i, req_valid_i, bus_is_32_i, map_valid_o,
    input wire logic        halfword_byte_lane_o, bank_select_hi_o, bank_select_lo_o,
    input wire logic [27:0] cpu_addr_i,
    input wire logic [1:0]  col_cfg_i, row_cfg_i, byte_lane_o, bank_field_o,
    input wire logic [10:0] column_o,
    input wire logic [12:0] row_o);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    wire [27:0] sh = bus_is_32_i ? cpu_addr_i >> 2 : cpu_addr_i >> 1;
    wire [4:0]  cw = 5'h8 + {3'h0, col_cfg_i};
    wire [4:0]  rw = row_cfg_i[1] ? 5'hD : 5'hB + {4'h0, row_cfg_i[0]};
    wire [27:0] ec = sh & ~(28'hFFFFFFF << cw);
    wire [27:0] er = (sh >> cw) & ~(28'hFFFFFFF << rw);
    wire [27:0] eb = sh >> (cw + rw);
    a_valid_delay: assert property (map_valid_o == $past(req_valid_i)) else $error("valid");
    a_lane_wide: assert property (req_valid_i && bus_is_32_i |=>
        byte_lane_o == $past(cpu_addr_i[1:0])) else $error("lane wide");
    a_lane_narrow: assert property (req_valid_i && !bus_is_32_i |=>
        byte_lane_o == {1'b0, $past(cpu_addr_i[0])} &&
        halfword_byte_lane_o == $past(cpu_addr_i[0])) else $error("lane narrow");
    a_column_field: assert property (req_valid_i |=> column_o == $past(ec[10:0]))
        else $error("column");
    a_row_field: assert property (req_valid_i |=> row_o == $past(er[12:0]))
        else $error("row");
    a_bank_field: assert property (req_valid_i |=> bank_field_o == $past(eb[1:0]))
        else $error("bank");
    a_bank_pins: assert property (req_valid_i |=>
        {bank_select_hi_o, bank_select_lo_o} == $past(eb[1:0])) else $error("pins");
    a_fields_hold: assert property (!req_valid_i |=>
        $stable(row_o) && $stable(column_o) && $stable(bank_field_o) && $stable(byte_lane_o))
        else $error("hold");
endmodule // sdram_addr_map_checker
bind sdram_addr_map sdram_addr_map_checker i_chk(.*);
`default_nettype wire

//--- sim/bank_pin_model.sv
// far side: sdram bank decode from the two bank pins
// assumes pins count only while map valid is high
`timescale 1ns/1ps
`default_nettype none
module bank_pin_model
(
    input  wire logic        map_valid_i,
    input  wire logic        bank_hi_i,
    input  wire logic        bank_lo_i,
    output logic [3:0]       bank_onehot_o
);
    // no bank while idle, so stale pins never select
    assign bank_onehot_o = map_valid_i ? 4'h1 << {bank_hi_i, bank_lo_i} : 4'h0;
endmodule // bank_pin_model
`default_nettype wire

//--- sim/testbench.sv
// testbench: address split over every bus, column and row setting
// drives i_dut directly; bank pins go to the far-side model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, nrst = 0, v = 0, b32 = 0, mv, hl, bh, bl;
    logic [27:0] a = 0;
    logic [1:0]  cc = 0, rc = 0, lane, bk;
    logic [10:0] col;
    logic [12:0] row;
    wire  [3:0]  oh;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    always #5 clk = ~clk;
    sdram_addr_map i_dut(.core_clk_i(clk), .nrst_i(nrst), .req_valid_i(v), .cpu_addr_i(a),
        .bus_is_32_i(b32), .col_cfg_i(cc), .row_cfg_i(rc), .map_valid_o(mv), .byte_lane_o(lane),
        .halfword_byte_lane_o(hl), .column_o(col), .row_o(row), .bank_field_o(bk),
        .bank_select_hi_o(bh), .bank_select_lo_o(bl));
    bank_pin_model i_mem(.map_valid_i(mv), .bank_hi_i(bh), .bank_lo_i(bl), .bank_onehot_o(oh));
    task chk(input string n, input logic [27:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // every setting, request then idle cycle
    task t_split(input logic [27:0] x);
        int l, c, r;
        for (int k = 0; k < 32; k++)
        begin
            l = 1 + k % 2;
            c = 8 + k / 2 % 4;
            r = (k < 16) ? 11 + k / 8 : 13; // reserved row code acts as 8K
            @(posedge clk);
            b32 <= k[0];
            cc <= 2'(k / 2);
            rc <= 2'(k / 8);
            @(posedge clk);
            v <= 1;
            a <= x;
            @(posedge clk);
            v <= 0;
            #1 chk("valid", 1, mv);
            chk("lane", b32 ? x[1:0] : {1'b0, x[0]}, lane);
            chk("half lane", x[0], hl);
            chk("col", (x >> l) % (1 << c), col);
            chk("row", (x >> (l + c)) % (1 << r), row);
            chk("bank", (x >> (l + c + r)) % 4, bk);
            chk("pins", 4'h1 << ((x >> (l + c + r)) % 4), oh);
            @(posedge clk);
            #1 chk("idle valid", 0, mv);
            chk("idle col", (x >> l) % (1 << c), col);
            chk("idle row", (x >> (l + c)) % (1 << r), row);
        end
        $display("split test done for %h", x);
    endtask
    // mid-run reset clears all outputs; a request at release is taken
    task t_reset;
        @(posedge clk);
        v <= 1;
        a <= 28'hFFFFFFF;
        @(posedge clk);
        v <= 0;
        nrst <= 0;
        #1 chk("rst fields", 0, {col, row, bk, bh, bl});
        chk("rst flags", 0, {mv, lane, hl});
        chk("rst pins", 0, oh);
        repeat (2) @(posedge clk);
        nrst <= 1;
        v <= 1;
        a <= 28'h0000004;
        @(posedge clk);
        v <= 0;
        #1 chk("rst valid", 1, mv);
        chk("rst col", 1, col);
        $display("reset test done");
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            miscompares++;
            end_of_test;
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        t_split(28'h5A5C3B7);
        t_reset;
        t_split(28'hFFFFFFF);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
